// ===== rcl_pkg.sv
package rcl_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // Definition flag follows lock by about one reference period
  localparam int DEF_DELAY_NS = 37;
  localparam int DEF_DELAY_RAW = (DEF_DELAY_NS * CLK_MHZ) / 1000;
  localparam int DEF_DELAY_CYC = (DEF_DELAY_RAW < 1) ? 1 : DEF_DELAY_RAW;
  // Typical acquisition times and the longest loss-of-lock delay
  localparam int ACQ_FIXED_US = 1000;
  localparam int ACQ_AUTO_US = 10000;
  localparam int LOSS_MAX_US = 1000;
  localparam int ACQ_FIXED_CYC = ACQ_FIXED_US * CLK_MHZ;
  localparam int ACQ_AUTO_CYC = ACQ_AUTO_US * CLK_MHZ;
  localparam int LOSS_MAX_CYC = LOSS_MAX_US * CLK_MHZ;
  // Input counts as present while an edge was seen in this window
  localparam int ACT_WINDOW_CYC = 64;

  localparam logic [1:0] SEL_AUTO = 2'h0;
  localparam logic [1:0] SEL_270 = 2'h1;
  localparam logic [1:0] SEL_HD = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;

  localparam logic [2:0] DET_NONE = 3'h0;
  localparam logic [2:0] DET_143 = 3'h1;
  localparam logic [2:0] DET_270 = 3'h2;
  localparam logic [2:0] DET_1483 = 3'h3;
  localparam logic [2:0] DET_1485 = 3'h4;
  localparam logic [2:0] DET_177 = 3'h5;
  localparam logic [2:0] DET_360 = 3'h6;
  localparam logic [2:0] DET_540 = 3'h7;

  typedef struct packed {
    logic [1:0] rate_sel;
    logic mute_n;
    logic bypass;
    logic clk_sel;
  } rcl_ctrl_t;

  typedef struct packed {
    logic p;
    logic n;
  } rcl_diff_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_LOCK} rcl_lock_st_t;

  // Reset values mirror the pad pulls: selector low, mute high, rest low
  localparam rcl_ctrl_t CTRL_RST = '{rate_sel: 2'h0, mute_n: 1'b1,
                                     bypass: 1'b0, clk_sel: 1'b0};
  localparam logic [5:0] LINE_RST = 6'h00;
  localparam rcl_diff_t DIFF_MUTED = '{p: 1'b0, n: 1'b1};
endpackage

// ===== rcl_sync.sv
`timescale 1ns/1ns
module rcl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
    if (!rst_b) begin
      next_meta = RST;
      next_q = RST;
    end
  end

  always_ff @(posedge clock) begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule

// ===== rcl_lock.sv
`timescale 1ns/1ns
module rcl_lock #(
  parameter int ACQ_FIXED_CYC = rcl_pkg::ACQ_FIXED_CYC,
  parameter int ACQ_AUTO_CYC = rcl_pkg::ACQ_AUTO_CYC
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic data_edge, // Transition seen on the serial input
  input wire logic pll_lock, // Synchronised analog loop lock
  input wire logic [2:0] det_rate, // Synchronised detected rate
  input wire logic [1:0] rate_sel, // Synchronised rate selector
  output logic locked, // Data present, loop locked, rate supported
  output logic sd_rate // Locked rate is standard definition
);
  localparam int TW = $clog2(ACQ_AUTO_CYC + 1);
  localparam int AW = $clog2(rcl_pkg::ACT_WINDOW_CYC + 1);

  // Refuse counts that the acquisition timer cannot serve
  if (ACQ_FIXED_CYC < 1 || ACQ_AUTO_CYC < ACQ_FIXED_CYC) begin : g_bad_acq
    $error("acquisition counts out of range");
  end

  rcl_pkg::rcl_lock_st_t st, next_st;
  logic [TW-1:0] timer, next_timer, target;
  logic [AW-1:0] idle_cnt, next_idle_cnt;
  logic [2:0] lock_rate, next_lock_rate;
  logic rate_ok, active, cond;

  always_comb begin
    unique case (rate_sel)
      rcl_pkg::SEL_AUTO: rate_ok = det_rate == rcl_pkg::DET_143 || // RL1
        det_rate == rcl_pkg::DET_270 || det_rate == rcl_pkg::DET_1483 ||
        det_rate == rcl_pkg::DET_1485;
      rcl_pkg::SEL_270: rate_ok = det_rate == rcl_pkg::DET_270; // RL2
      rcl_pkg::SEL_HD: rate_ok = det_rate == rcl_pkg::DET_1483 || // RL20
        det_rate == rcl_pkg::DET_1485;
      default: rate_ok = 1'b0; // RL20
    endcase
    active = idle_cnt < AW'(rcl_pkg::ACT_WINDOW_CYC);
    cond = active && pll_lock && rate_ok; // RL4 RL18
    target = (rate_sel == rcl_pkg::SEL_AUTO) ? TW'(ACQ_AUTO_CYC - 1)
                                               : TW'(ACQ_FIXED_CYC - 1);
    next_idle_cnt = idle_cnt;
    if (data_edge)
      next_idle_cnt = '0;
    else if (active)
      next_idle_cnt = idle_cnt + AW'(1);
    next_st = st;
    next_timer = timer;
    next_lock_rate = lock_rate;
    case (st)
      rcl_pkg::ST_IDLE: begin
        next_timer = '0;
        if (cond)
          next_st = rcl_pkg::ST_ACQ;
      end
      rcl_pkg::ST_ACQ: begin
        next_timer = timer + TW'(1);
        if (!cond) begin
          next_st = rcl_pkg::ST_IDLE;
        end else if (timer >= target) begin
          next_st = rcl_pkg::ST_LOCK;
          next_lock_rate = det_rate;
        end
      end
      rcl_pkg::ST_LOCK: begin
        if (!cond || det_rate != lock_rate) // RL14
          next_st = rcl_pkg::ST_IDLE;
      end
      default: next_st = rcl_pkg::ST_IDLE;
    endcase
    if (!rst_b) begin
      next_st = rcl_pkg::ST_IDLE;
      next_timer = '0;
      next_idle_cnt = AW'(rcl_pkg::ACT_WINDOW_CYC);
      next_lock_rate = rcl_pkg::DET_NONE;
    end
  end

  always_ff @(posedge clock) begin
    st <= next_st;
    timer <= next_timer;
    idle_cnt <= next_idle_cnt;
    lock_rate <= next_lock_rate;
  end

  assign locked = st == rcl_pkg::ST_LOCK;
  assign sd_rate = lock_rate == rcl_pkg::DET_143 || // RL11
                   lock_rate == rcl_pkg::DET_270;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  rate_loss_a: assert property ( // RL14
      locked && det_rate != lock_rate |=> !locked)
    else $error("lock kept after rate change");
  // A selector change while locked is allowed one cycle to drop the lock
  slow_auto_a: assert property (locked && lock_rate == rcl_pkg::DET_143 // RL1
      && rate_sel != rcl_pkg::SEL_AUTO |=> !locked)
    else $error("143 locked outside automatic mode");
  fixed_rate_a: assert property (locked && rate_sel == rcl_pkg::SEL_270 // RL2
      |=> !locked || lock_rate == rcl_pkg::DET_270)
    else $error("fixed 270 mode locked to other rate");
  odd_rate_a: assert property (locked |-> lock_rate != rcl_pkg::DET_177 && // RL18
      lock_rate != rcl_pkg::DET_360 && lock_rate != rcl_pkg::DET_540)
    else $error("locked to unsupported rate");
endmodule

// ===== rcl_top.sv
`timescale 1ns/1ns
// Operation
// RL1: Selector 00 runs automatic rate search; 143 Mbps locks only there.
// RL2: Selector 01 fixes 270 Mbps, also used for 8B10B coded streams.
// RL3: Undriven selector pins read low, giving automatic rate search.
// RL4: Lock indicator high only with data present and loop locked.
// RL5: Low mute input mutes both outputs, above any bypass setting.
// RL6: Undriven mute input reads high, outputs enabled.
// RL7: High bypass input passes data unretimed unless muted.
// RL8: Low bypass input bypasses while unlocked or rate unsupported.
// RL9: Undriven bypass input reads low, automatic bypass.
// RL10: Mute tied to lock indicator mutes while unlocked, else per bypass.
// RL11: Definition flag high for 270 or 143, low for 1483 or 1485.
// RL12: Definition flag is registered, low whenever unlocked.
// RL13: Definition flag settles one reference period after lock changes.
// RL14: Lock drops within 1 ms of a rate change; flag invalid meanwhile.
// RL15: Clock select high gives clock on second output, low gives data.
// RL16: Board supplies the 27 MHz reference, crystal or clock.
// RL17: Second output in clock mode is muted during bypass.
// RL18: No lock to 177, 360 or 540 Mbps; bypass instead.
// RL19: Muted outputs sit with legs at opposite fixed levels.
// RL20: Selector 10 fixes high definition rates, 11 forces test bypass.
module rcl_top #(
  parameter int ACQ_FIXED_CYC = rcl_pkg::ACQ_FIXED_CYC,
  parameter int ACQ_AUTO_CYC = rcl_pkg::ACQ_AUTO_CYC
) (
  input wire logic clock, // 20 MHz system clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [1:0] rate_select, // Rate selector pins
  input wire logic mute_n, // Output mute, active low
  input wire logic bypass, // Forced reclocker bypass
  input wire logic clock_output_select, // Second output carries clock
  input wire logic serial_video_input, // Serial data from equalizer
  input wire logic pll_lock, // Analog loop lock status
  input wire logic [2:0] detected_rate, // Analog rate detector code
  input wire logic recovered_clock, // Recovered data-rate clock
  output logic lock_indicator, // Locked with data present
  output logic definition_class_flag, // High for standard definition
  output logic automatic_rate_search, // Automatic rate search active
  output rcl_pkg::rcl_diff_t primary_serial_output, // First output
  output rcl_pkg::rcl_diff_t second_serial_output // Data or clock
);
  rcl_pkg::rcl_ctrl_t ctl;
  logic [5:0] line_s;
  logic sdi_s, pll_s, rclk_s;
  logic [2:0] det_s;

  // Reset values stand in for the pad pulls until pins are sampled
  rcl_sync #(
    .W(5),
    .RST(rcl_pkg::CTRL_RST) // RL3 RL6 RL9
  ) u_ctrl_sync (
    .clock(clock),
    .rst_b(rst_b),
    .d({rate_select, mute_n, bypass, clock_output_select}),
    .q(ctl)
  );

  rcl_sync #(
    .W(6),
    .RST(rcl_pkg::LINE_RST)
  ) u_line_sync (
    .clock(clock),
    .rst_b(rst_b),
    .d({serial_video_input, pll_lock, detected_rate, recovered_clock}),
    .q(line_s)
  );

  assign sdi_s = line_s[5];
  assign pll_s = line_s[4];
  assign det_s = line_s[3:1];
  assign rclk_s = line_s[0];

  logic sdi_q, retimed, lock_int, sd_rate;
  logic next_sdi_q, next_retimed;

  rcl_lock #(
    .ACQ_FIXED_CYC(ACQ_FIXED_CYC),
    .ACQ_AUTO_CYC(ACQ_AUTO_CYC)
  ) u_lock (
    .clock(clock),
    .rst_b(rst_b),
    .data_edge(sdi_s ^ sdi_q),
    .pll_lock(pll_s),
    .det_rate(det_s),
    .rate_sel(ctl.rate_sel),
    .locked(lock_int),
    .sd_rate(sd_rate)
  );

  // Retiming stage and edge history
  always_comb begin
    next_sdi_q = sdi_s;
    next_retimed = sdi_s;
    if (!rst_b) begin
      next_sdi_q = 1'b0;
      next_retimed = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    sdi_q <= next_sdi_q;
    retimed <= next_retimed;
  end

  logic byp_eff, data_sel, sel_test;
  logic next_lock, next_def, next_auto;
  rcl_pkg::rcl_diff_t next_prim, next_sec, data_pair;

  always_comb begin
    sel_test = ctl.rate_sel == rcl_pkg::SEL_TEST; // RL20
    byp_eff = ctl.bypass | ~lock_int | sel_test; // RL7 RL8 RL18
    data_sel = byp_eff ? sdi_s : retimed;
    data_pair = '{p: data_sel, n: ~data_sel};
    next_lock = lock_int; // RL4
    // Registered from the lock flop, so it trails lock by one cycle
    next_def = lock_indicator & sd_rate; // RL11 RL12 RL13
    next_auto = ctl.rate_sel == rcl_pkg::SEL_AUTO; // RL1
    next_prim = data_pair;
    next_sec = data_pair; // RL15
    if (ctl.clk_sel) begin
      if (byp_eff)
        next_sec = rcl_pkg::DIFF_MUTED; // RL17
      else
        next_sec = '{p: rclk_s, n: ~rclk_s}; // RL15
    end
    // Mute wins over bypass; a tie to the lock output mutes when unlocked
    if (!ctl.mute_n) begin
      next_prim = rcl_pkg::DIFF_MUTED; // RL5 RL10 RL19
      next_sec = rcl_pkg::DIFF_MUTED; // RL5 RL19
    end
    if (!rst_b) begin
      next_lock = 1'b0;
      next_def = 1'b0;
      next_auto = 1'b1;
      next_prim = rcl_pkg::DIFF_MUTED;
      next_sec = rcl_pkg::DIFF_MUTED;
    end
  end

  always_ff @(posedge clock) begin
    lock_indicator <= next_lock;
    definition_class_flag <= next_def;
    automatic_rate_search <= next_auto;
    primary_serial_output <= next_prim;
    second_serial_output <= next_sec;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_mute_req;
    !ctl.mute_n;
  endsequence

  sequence s_both_muted;
    primary_serial_output == rcl_pkg::DIFF_MUTED &&
    second_serial_output == rcl_pkg::DIFF_MUTED;
  endsequence

  sequence s_lock_rise;
    $rose(lock_indicator) && sd_rate;
  endsequence

  mute_out_a: assert property (s_mute_req |=> s_both_muted) // RL5
    else $error("outputs not muted");
  mute_legs_a: assert property (!ctl.mute_n |=> // RL19
      primary_serial_output.p != primary_serial_output.n)
    else $error("muted legs not opposite");
  force_byp_a: assert property (ctl.mute_n && ctl.bypass // RL7
      |=> primary_serial_output.p == $past(sdi_s))
    else $error("forced bypass not unretimed");
  auto_byp_a: assert property (ctl.mute_n && !ctl.bypass && !lock_int // RL8
      |=> primary_serial_output.p == $past(sdi_s))
    else $error("unlocked data not bypassed");
  retime_a: assert property (ctl.mute_n && !byp_eff // RL8
      |=> primary_serial_output.p == $past(retimed))
    else $error("locked data not retimed");
  lock_src_a: assert property (lock_indicator // RL4
      |-> $past(pll_s, 2) && $past(lock_int))
    else $error("lock shown without loop lock");
  def_low_a: assert property (!lock_indicator |=> // RL12
      !definition_class_flag)
    else $error("definition flag high while unlocked");
  def_sd_a: assert property (s_lock_rise |=> definition_class_flag) // RL13
    else $error("definition flag late after lock");
  def_hd_a: assert property (lock_indicator && !sd_rate // RL11
      |=> !definition_class_flag)
    else $error("definition flag high at hd rate");
  clk_mute_a: assert property (ctl.clk_sel && byp_eff // RL17
      |=> second_serial_output == rcl_pkg::DIFF_MUTED)
    else $error("clock output live in bypass");
  sec_data_a: assert property (ctl.mute_n && !ctl.clk_sel // RL15
      |=> second_serial_output == primary_serial_output)
    else $error("second output not carrying data");
  sec_clk_a: assert property (ctl.mute_n && ctl.clk_sel && !byp_eff // RL15
      |=> second_serial_output.p == $past(rclk_s))
    else $error("second output not carrying clock");
  // Lock taken before the test selection drops one cycle later
  test_byp_a: assert property (ctl.rate_sel == rcl_pkg::SEL_TEST // RL20
      |=> !lock_int)
    else $error("lock in test selection");
endmodule

// ===== rcl_front_model.sv
`timescale 1ns/1ns
module rcl_front_model (
  input wire logic clock, // Bench clock
  input wire logic [1:0] mode, // 0 idle, 1 data and lock, 2 data only
  input wire logic [2:0] rate, // Rate code reported while active
  input wire logic idle_level, // Line level held while idle
  output logic data_out, // Serial stream toward the reclocker
  output logic pll_lock, // Loop lock status
  output logic [2:0] detected_rate, // Rate detector code
  output logic recovered_clock // Data-rate clock, still while idle
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    data_out = 1'b0;
    pll_lock = 1'b0;
    detected_rate = rcl_pkg::DET_NONE;
    recovered_clock = 1'b0;
  end
  // Stream has uneven runs so a stuck output cannot pass for data
  always @(negedge clock) begin
    cnt <= cnt + 4'h1;
    recovered_clock <= (mode != 2'h0) ? ~recovered_clock : 1'b0;
    data_out <= (mode != 2'h0) ? (cnt[0] ^ cnt[2]) : idle_level;
    pll_lock <= (mode == 2'h1);
    detected_rate <= (mode == 2'h0) ? rcl_pkg::DET_NONE : rate;
  end
endmodule

// ===== rcl_top_tb.sv
`timescale 1ns/1ns
module rcl_top_tb;
  typedef struct packed {
    logic [1:0] sel;
    logic [2:0] det;
    logic [1:0] mode;
    logic [2:0] ctl; // bypass, mute_n, clock select
    logic [3:0] exp; // lock, class flag, first muted, second muted
  } rcl_row_t;
  localparam rcl_row_t ROWS [14] = '{
    '{2'h0, 3'h2, 2'h1, 3'h2, 4'hC}, '{2'h0, 3'h1, 2'h1, 3'h2, 4'hC},
    '{2'h0, 3'h4, 2'h1, 3'h2, 4'h8}, '{2'h0, 3'h3, 2'h1, 3'h3, 4'h8},
    '{2'h1, 3'h1, 2'h1, 3'h2, 4'h0}, '{2'h1, 3'h2, 2'h1, 3'h2, 4'hC},
    '{2'h2, 3'h4, 2'h1, 3'h2, 4'h8}, '{2'h3, 3'h2, 2'h1, 3'h3, 4'h1},
    '{2'h0, 3'h5, 2'h1, 3'h3, 4'h1}, '{2'h0, 3'h6, 2'h1, 3'h2, 4'h0},
    '{2'h0, 3'h7, 2'h1, 3'h2, 4'h0}, '{2'h0, 3'h2, 2'h2, 3'h2, 4'h0},
    '{2'h0, 3'h2, 2'h1, 3'h7, 4'hD}, '{2'h0, 3'h2, 2'h1, 3'h4, 4'hF}};
  logic clock, rst_b, mute_reg, mute_tie, bypass, clk_sel, idle_level;
  logic mute_n;
  logic [1:0] rate_select, mode;
  logic [2:0] det, detected_rate;
  logic serial_video_input, pll_lock, recovered_clock;
  logic lock_indicator, definition_class_flag, automatic_rate_search;
  rcl_pkg::rcl_diff_t primary_serial_output, second_serial_output;
  rcl_row_t r;
  int n_fail = 0;
  int cmp_count = 0;
  int n;

  // Board may tie the mute input to the lock indicator
  assign mute_n = mute_tie ? lock_indicator : mute_reg;

  rcl_front_model u_rcl_front_model (.clock(clock), .mode(mode),
    .rate(det), .idle_level(idle_level), .data_out(serial_video_input),
    .pll_lock(pll_lock), .detected_rate(detected_rate),
    .recovered_clock(recovered_clock));

  rcl_top #(.ACQ_FIXED_CYC(8), .ACQ_AUTO_CYC(16)) u_rcl_top (
    .clock(clock), .rst_b(rst_b), .rate_select(rate_select),
    .mute_n(mute_n), .bypass(bypass), .clock_output_select(clk_sel),
    .serial_video_input(serial_video_input), .pll_lock(pll_lock),
    .detected_rate(detected_rate), .recovered_clock(recovered_clock),
    .lock_indicator(lock_indicator),
    .definition_class_flag(definition_class_flag),
    .automatic_rate_search(automatic_rate_search),
    .primary_serial_output(primary_serial_output),
    .second_serial_output(second_serial_output));

  // Stands in for the 20 MHz system clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check_bit(input logic g, input logic e, input string m);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: %s got %b", $time, m, g);
    end
  endtask

  // Muted pair sits at fixed opposite legs, live pair is complementary
  task automatic check_out(input rcl_pkg::rcl_diff_t g, input logic muted);
    cmp_count++;
    if (muted ? (g !== rcl_pkg::DIFF_MUTED) : ((g.p ^ g.n) !== 1'b1)) begin
      n_fail++;
      $display("mismatch at %0t: output pair %b", $time, g);
    end
  endtask

  task automatic wait_lock(input logic v, input int lim, output int c);
    c = 0;
    while (lock_indicator !== v && c < lim) begin
      @(negedge clock);
      c++;
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    rate_select = 2'h0;
    mute_reg = 1'b1;
    mute_tie = 1'b0;
    bypass = 1'b0;
    clk_sel = 1'b0;
    idle_level = 1'b0;
    mode = 2'h0;
    det = 3'h0;
    repeat (16) @(negedge clock);
    check_bit(lock_indicator, 1'b0, "reset lock");
    check_bit(definition_class_flag, 1'b0, "reset class");
    check_bit(automatic_rate_search, 1'b1, "reset auto");
    check_out(primary_serial_output, 1'b1);
    rst_b = 1'b1;
    $display("reset test done");
    for (int i = 0; i < 14; i++) begin
      r = ROWS[i];
      rate_select = r.sel;
      det = r.det;
      mode = r.mode;
      {bypass, mute_reg, clk_sel} = r.ctl;
      repeat (60) @(negedge clock);
      check_bit(lock_indicator, r.exp[3], "lock");
      check_bit(definition_class_flag, r.exp[2], "class");
      check_bit(automatic_rate_search, r.sel == 2'h0, "auto");
      check_out(primary_serial_output, r.exp[1]);
      check_out(second_serial_output, r.exp[0]);
      $display("row %0d done", i);
    end
    // Rate change from standard to unsupported, then back
    {bypass, mute_reg, clk_sel} = 3'h2;
    repeat (60) @(negedge clock);
    det = rcl_pkg::DET_177;
    wait_lock(1'b0, rcl_pkg::LOSS_MAX_CYC, n);
    check_bit(n < rcl_pkg::LOSS_MAX_CYC, 1'b1, "loss time");
    @(negedge clock);
    check_bit(definition_class_flag, 1'b0, "class after loss");
    det = rcl_pkg::DET_270;
    wait_lock(1'b1, 200, n);
    @(negedge clock);
    check_bit(definition_class_flag, 1'b1, "class after lock");
    // Clock mode toggles every cycle while locked and retiming
    clk_sel = 1'b1;
    repeat (5) @(negedge clock);
    for (int k = 0; k < 4; k++) begin
      n = second_serial_output.p;
      @(negedge clock);
      check_bit(second_serial_output.p, ~n[0], "clock toggle");
    end
    $display("timing test done");
    // Mute tied to lock indicator
    clk_sel = 1'b0;
    mute_tie = 1'b1;
    mode = 2'h0;
    repeat (80) @(negedge clock);
    check_out(primary_serial_output, 1'b1);
    check_out(second_serial_output, 1'b1);
    mode = 2'h1;
    wait_lock(1'b1, 200, n);
    repeat (4) @(negedge clock);
    check_out(primary_serial_output, 1'b0);
    $display("tied mute test done");
    // Idle line passes through unretimed while unlocked
    mute_tie = 1'b0;
    idle_level = 1'b1;
    mode = 2'h0;
    repeat (80) @(negedge clock);
    check_bit(primary_serial_output.p, 1'b1, "bypass p");
    check_bit(primary_serial_output.n, 1'b0, "bypass n");
    check_bit(second_serial_output.p, 1'b1, "second data");
    clk_sel = 1'b1;
    repeat (5) @(negedge clock);
    check_out(second_serial_output, 1'b1);
    $display("bypass test done");
    // Second reset in mid-run from a locked state
    clk_sel = 1'b0;
    mode = 2'h1;
    wait_lock(1'b1, 200, n);
    check_bit(lock_indicator, 1'b1, "lock before reset");
    rst_b = 1'b0;
    repeat (4) @(negedge clock);
    check_bit(lock_indicator, 1'b0, "rereset lock");
    check_bit(definition_class_flag, 1'b0, "rereset class");
    rst_b = 1'b1;
    @(negedge clock);
    check_bit(lock_indicator, 1'b0, "lock after release");
    check_bit(automatic_rate_search, 1'b1, "auto after release");
    wait_lock(1'b1, 200, n);
    check_bit(lock_indicator, 1'b1, "relock after reset");
    $display("second reset test done");
    finish_test();
  end
endmodule
